// ### core/sadc_pkg.sv
// sadc_pkg: constants and types for the sar converter sequence/mux control
// assumes: apb slave with 32-bit data, one clock, synchronous active-low reset
package sadc_pkg;

  localparam logic [11:0] SADC_OFS_CTRL_ONE   = 12'h000;
  localparam logic [11:0] SADC_OFS_CTRL_TWO   = 12'h004;
  localparam logic [11:0] SADC_OFS_CTRL_THREE = 12'h008;
  localparam logic [11:0] SADC_OFS_MUX_SEL    = 12'h00c;
  localparam logic [11:0] SADC_OFS_PIN_CFG    = 12'h010;
  localparam logic [11:0] SADC_OFS_SCAN_MASK  = 12'h014;
  localparam logic [11:0] SADC_OFS_STATUS     = 12'h018;
  localparam logic [11:0] SADC_OFS_BUF_BASE   = 12'h040;

  // control_one fields
  localparam int SADC_C1_MODULE_ON  = 15;
  localparam int SADC_C1_TRIG_LSB   = 5;
  localparam int SADC_C1_AUTO_SAMPLE_NOW  = 2;
  localparam int SADC_C1_SAMPLE_NOW = 1;
  localparam int SADC_C1_DONE       = 0;
  // control_two fields
  localparam int SADC_C2_REF_LSB    = 13;
  localparam int SADC_C2_SCAN_EN    = 10;
  localparam int SADC_C2_SMPI_LSB   = 2;
  localparam int SADC_C2_ALT        = 0;
  // control_three fields
  localparam int SADC_C3_SAMC_LSB   = 8;
  localparam int SADC_C3_DIV_LSB    = 0;
  // mux select fields, byte-relative
  localparam int SADC_MUX_NEG       = 4;
  localparam int SADC_MUX_B_LSB     = 8;

  localparam logic [15:0] SADC_RST_REG     = 16'h0000;
  localparam logic [15:0] SADC_C1_WMASK    = 16'h80e7;
  localparam logic [15:0] SADC_C2_WMASK    = 16'he43d;
  localparam logic [15:0] SADC_C3_WMASK    = 16'h1f3f;
  localparam logic [15:0] SADC_MUX_WMASK   = 16'h1f1f;

  localparam int SADC_CONV_TAD = 14;

  // trigger source codes
  localparam logic [2:0] SADC_TRIG_MANUAL = 3'h0;
  localparam logic [2:0] SADC_TRIG_EXT0   = 3'h1;
  localparam logic [2:0] SADC_TRIG_EXT1   = 3'h2;
  localparam logic [2:0] SADC_TRIG_EXT2   = 3'h3;
  localparam logic [2:0] SADC_TRIG_AUTO   = 3'h7;

  typedef enum logic [1:0]
  {
    SADC_IDLE   = 2'b00,
    SADC_SAMPLE = 2'b01,
    SADC_CONV   = 2'b10
  } sadc_state_t;

endpackage

// ### core/sadc_result_mem.sv
// sadc_result_mem: 16-word result buffer with registered read data
// assumes: single clock, one write port, one read port
`timescale 1ns/1ps
module sadc_result_mem
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
)
(
  // clock
  input  wire logic                     clk,
  // write side
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  // read side
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// ### core/sadc_ctrl.sv
// sadc_ctrl: apb register file and sample/convert sequencer of the sar converter
// assumes: analog front end returns the result bits in conv_result at conversion end
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module sadc_ctrl
  import sadc_pkg::*;
#(
  parameter int RES_BITS = 12
)
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // hardware trigger sources
  input  wire logic [2:0]          hw_trigger,
  // analog front end
  input  wire logic [RES_BITS-1:0] conv_result,
  output logic                     sample_connect,
  output logic      [3:0]          pos_input_sel,
  output logic                     neg_input_sel,
  output logic      [15:0]         pin_digital_mode_bits,
  output logic      [2:0]          reference_config,
  output logic                     module_on,
  output logic                     tad_tick,
  // interrupt pulse to cpu
  output logic                     converter_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [15:0]   ctrl_one;
    logic [15:0]   ctrl_two;
    logic [15:0]   ctrl_three;
    logic [15:0]   mux_sel;
    logic [15:0]   pin_cfg;
    logic [15:0]   scan_mask;
    sadc_state_t   state;
    logic [5:0]    div_cnt;
    logic [4:0]    tad_cnt;
    logic [3:0]    seq_cnt;
    logic [3:0]    buf_ptr;
    logic [3:0]    scan_pos;
    logic          use_b;
    logic          irq;
    logic          rd_pend;
    logic [31:0]   rdata;
  } sadc_regs_t;

  sadc_regs_t r;
  sadc_regs_t next_r;

  logic [RES_BITS-1:0] mem_rdata;
  logic                mem_wr;
  logic                tick;
  logic                wr_acc;
  logic                rd_acc;
  logic                is_buf;
  logic                trig_hit;
  logic [3:0]          scan_input;

  // lowest set bit of mask at or above a position
  function automatic logic [3:0] next_scan(input logic [15:0] mask, input logic [3:0] from);
    logic [3:0] res;
    logic       found;
    res   = from;
    found = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      if (!found && i >= from && mask[i])
      begin
        res   = 4'(i);
        found = 1'b1;
      end
    end
    return res;
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [15:0] m);
    return (old & ~m) | (wd[15:0] & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  assign is_buf  = paddr[11:6] == SADC_OFS_BUF_BASE[11:6];
  assign wr_acc  = psel && penable && pwrite && pready;
  assign rd_acc  = psel && !penable && !pwrite;
  assign tick    = r.div_cnt == r.ctrl_three[SADC_C3_DIV_LSB +: 6];
  assign scan_input = next_scan(r.scan_mask, r.scan_pos);

  always_comb
  begin
    unique case (r.ctrl_one[SADC_C1_TRIG_LSB +: 3])
      SADC_TRIG_EXT0: trig_hit = hw_trigger[0];
      SADC_TRIG_EXT1: trig_hit = hw_trigger[1];
      SADC_TRIG_EXT2: trig_hit = hw_trigger[2];
      SADC_TRIG_AUTO: trig_hit = tick &&
                                 r.tad_cnt >= r.ctrl_three[SADC_C3_SAMC_LSB +: 5];
      default:        trig_hit = !r.ctrl_one[SADC_C1_SAMPLE_NOW];
    endcase
  end

  sadc_result_mem #(
    .WIDTH (RES_BITS),
    .DEPTH (16)
  ) u_mem (
    .clk     (clk),
    .wr_en   (mem_wr),
    .wr_addr (r.buf_ptr),
    .wr_data (conv_result),
    .rd_addr (paddr[5:2]),
    .rd_data (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    next_r = r;
    mem_wr = 1'b0;
    next_r.irq = 1'b0;
    next_r.rd_pend = rd_acc;
    next_r.div_cnt = tick ? 6'h00 : r.div_cnt + 6'h01;

    // register writes; pin and scan masks store the whole halfword, mux settings only their writable bits
    if (wr_acc)
    begin
      unique case (paddr)
        SADC_OFS_CTRL_ONE:   next_r.ctrl_one   = merge(r.ctrl_one, pwdata, SADC_C1_WMASK);
        SADC_OFS_CTRL_TWO:   next_r.ctrl_two   = merge(r.ctrl_two, pwdata, SADC_C2_WMASK);
        SADC_OFS_CTRL_THREE: next_r.ctrl_three = merge(r.ctrl_three, pwdata, SADC_C3_WMASK);
        SADC_OFS_MUX_SEL:    next_r.mux_sel    = merge(r.mux_sel, pwdata, SADC_MUX_WMASK);
        SADC_OFS_PIN_CFG:    next_r.pin_cfg    = pwdata[15:0];
        SADC_OFS_SCAN_MASK:  next_r.scan_mask  = pwdata[15:0];
        default:             next_r.mux_sel    = next_r.mux_sel;
      endcase
    end

    if (!r.ctrl_one[SADC_C1_MODULE_ON])
    begin
      // off: sequencer parked, counters fresh
      next_r.state    = SADC_IDLE;
      next_r.seq_cnt  = 4'h0;
      next_r.scan_pos = 4'h0;
      next_r.use_b    = 1'b0;
      next_r.buf_ptr  = 4'h0;
      next_r.tad_cnt  = 5'h00;
    end
    else
    begin
      unique case (r.state)
        SADC_IDLE:
        begin
          if (r.ctrl_one[SADC_C1_SAMPLE_NOW] || r.ctrl_one[SADC_C1_AUTO_SAMPLE_NOW])
          begin
            next_r.state   = SADC_SAMPLE;
            next_r.tad_cnt = 5'h00;
            next_r.ctrl_one[SADC_C1_SAMPLE_NOW] = 1'b1;
          end
        end
        SADC_SAMPLE:
        begin
          if (tick && r.tad_cnt != 5'h1f)
          begin
            next_r.tad_cnt = r.tad_cnt + 5'h01;
          end
          if (trig_hit)
          begin
            next_r.state   = SADC_CONV;
            next_r.tad_cnt = 5'h00;
            next_r.ctrl_one[SADC_C1_SAMPLE_NOW] = 1'b0;
            next_r.ctrl_one[SADC_C1_DONE] = 1'b0;
          end
        end
        SADC_CONV:
        begin
          if (tick)
          begin
            next_r.tad_cnt = r.tad_cnt + 5'h01;
          end
          if (tick && r.tad_cnt == 5'(SADC_CONV_TAD - 1))
          begin
            mem_wr = 1'b1;
            next_r.buf_ptr = r.buf_ptr + 4'h1;
            next_r.ctrl_one[SADC_C1_DONE] = 1'b1;
            next_r.tad_cnt = 5'h00;
            if (r.ctrl_two[SADC_C2_ALT])
            begin
              next_r.use_b = !r.use_b;
            end
            if (r.ctrl_two[SADC_C2_SCAN_EN] && !r.use_b)
            begin
              next_r.scan_pos = scan_input + 4'h1;
            end
            if (r.seq_cnt == r.ctrl_two[SADC_C2_SMPI_LSB +: 4])
            begin
              next_r.irq      = 1'b1;
              next_r.seq_cnt  = 4'h0;
              next_r.scan_pos = 4'h0;
              next_r.buf_ptr  = 4'h0;
              next_r.use_b    = 1'b0;
            end
            else
            begin
              next_r.seq_cnt = r.seq_cnt + 4'h1;
            end
            if (r.ctrl_one[SADC_C1_AUTO_SAMPLE_NOW])
            begin
              next_r.state = SADC_SAMPLE;
              next_r.ctrl_one[SADC_C1_SAMPLE_NOW] = 1'b1;
            end
            else
            begin
              next_r.state = SADC_IDLE;
            end
          end
        end
        default: next_r.state = SADC_IDLE;
      endcase
    end

    // read data captured in the setup cycle
    next_r.rdata = 32'h0000_0000;
    if (rd_acc)
    begin
      unique case (paddr)
        SADC_OFS_CTRL_ONE:   next_r.rdata = {16'h0000, r.ctrl_one};
        SADC_OFS_CTRL_TWO:   next_r.rdata = {16'h0000, r.ctrl_two};
        SADC_OFS_CTRL_THREE: next_r.rdata = {16'h0000, r.ctrl_three};
        SADC_OFS_MUX_SEL:    next_r.rdata = {16'h0000, r.mux_sel};
        SADC_OFS_PIN_CFG:    next_r.rdata = {16'h0000, r.pin_cfg};
        SADC_OFS_SCAN_MASK:  next_r.rdata = {16'h0000, r.scan_mask};
        SADC_OFS_STATUS:     next_r.rdata = {16'h0000, r.buf_ptr, r.seq_cnt,
                                             r.scan_pos, r.use_b, 1'b0, r.state};
        default:             next_r.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // read data captured on the setup edge, so buffer words come out of the memory register
  assign pready  = !psel || !penable || pwrite || r.rd_pend;
  assign pslverr = 1'b0;
  assign prdata  = is_buf ? 32'(mem_rdata) : r.rdata;

  // one channel, fed by mux a or b
  assign pos_input_sel = r.use_b ? r.mux_sel[SADC_MUX_B_LSB +: 4] :
                         r.ctrl_two[SADC_C2_SCAN_EN] ? scan_input :
                         r.mux_sel[3:0];
  assign neg_input_sel = r.use_b ? r.mux_sel[SADC_MUX_B_LSB + SADC_MUX_NEG] :
                         r.mux_sel[SADC_MUX_NEG];
  assign sample_connect        = r.state == SADC_SAMPLE;
  assign pin_digital_mode_bits = r.pin_cfg;
  assign reference_config      = r.ctrl_two[SADC_C2_REF_LSB +: 3];
  assign module_on             = r.ctrl_one[SADC_C1_MODULE_ON];
  assign tad_tick              = tick;
  assign converter_irq         = r.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // check helper only: converter periods seen so far in the running conversion
  logic [4:0] conv_ticks;

  always_ff @(posedge clk)
  begin
    if (!rst_n || r.state != SADC_CONV)
    begin
      conv_ticks <= 5'h00;
    end
    else if (tick)
    begin
      conv_ticks <= conv_ticks + 5'h01;
    end
  end

  // a conversion cut by switching off is not judged
  property p_conv_len;
    @(posedge clk) disable iff (!rst_n)
    r.state == SADC_CONV && next_r.state != SADC_CONV && module_on |->
      tick && conv_ticks == 5'(SADC_CONV_TAD - 1);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_off_idle;
    @(posedge clk) disable iff (!rst_n)
    !module_on |=> r.state == SADC_IDLE && r.seq_cnt == 4'h0;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("off did not park");

  property p_irq_cnt;
    @(posedge clk) disable iff (!rst_n)
    converter_irq |-> r.seq_cnt == 4'h0 && $past(r.seq_cnt) == r.ctrl_two[5:2];
  endproperty
  a_irq_cnt: assert property (p_irq_cnt) else $error("irq count wrong");

  property p_auto;
    @(posedge clk) disable iff (!rst_n)
    $fell(r.state == SADC_CONV) && module_on && r.ctrl_one[SADC_C1_AUTO_SAMPLE_NOW]
      |-> r.state == SADC_SAMPLE;
  endproperty
  a_auto: assert property (p_auto) else $error("auto sample missed");

  property p_manual_trig;
    @(posedge clk) disable iff (!rst_n)
    r.state == SADC_SAMPLE && module_on && r.ctrl_one[7:5] == SADC_TRIG_MANUAL
      && !r.ctrl_one[SADC_C1_SAMPLE_NOW] |=> r.state == SADC_CONV;
  endproperty
  a_manual_trig: assert property (p_manual_trig) else $error("manual trigger");

  property p_mux_a;
    @(posedge clk) disable iff (!rst_n)
    !r.use_b && !r.ctrl_two[SADC_C2_SCAN_EN] |->
      pos_input_sel == r.mux_sel[3:0] && neg_input_sel == r.mux_sel[4];
  endproperty
  a_mux_a: assert property (p_mux_a) else $error("mux a routing");

  property p_alt_off;
    @(posedge clk) disable iff (!rst_n)
    !r.ctrl_two[SADC_C2_ALT] && !r.use_b |=> !r.use_b;
  endproperty
  a_alt_off: assert property (p_alt_off) else $error("mux b used");

  property p_connect;
    @(posedge clk) disable iff (!rst_n)
    r.state == SADC_SAMPLE && module_on && trig_hit |=> !sample_connect;
  endproperty
  a_connect: assert property (p_connect) else $error("connected in conv");

  c_irq:  cover property (@(posedge clk) disable iff (!rst_n) converter_irq);
  c_altb: cover property (@(posedge clk) disable iff (!rst_n) r.use_b && sample_connect);
  c_auto: cover property (@(posedge clk) disable iff (!rst_n)
                          r.ctrl_one[7:5] == SADC_TRIG_AUTO && mem_wr);

endmodule

// ### tb/sadc_afe_model.sv
// sadc_afe_model: behavioural sample-hold and sar front end seen by the sequencer
// assumes: result may be taken by the sequencer up to the fourteenth converter tick
`timescale 1ns/1ps
module sadc_afe_model
(
  // clock
  input  wire logic        clk,
  // controls from the sequencer
  input  wire logic        sample_connect,
  input  wire logic [3:0]  pos_input_sel,
  input  wire logic        neg_input_sel,
  input  wire logic [15:0] pin_digital_mode_bits,
  input  wire logic        tad_tick,
  // result to the sequencer
  output logic      [11:0] conv_result
);
  logic [11:0] held = 12'h000;
  int          ticks = 99;

  // one channel: the value tracks the mux until it is disconnected
  always @(posedge clk)
  begin
    if (sample_connect)
    begin
      // digital pins feed ground into the mux
      held  <= pin_digital_mode_bits[pos_input_sel] ? 12'h000 :
               {7'h40, neg_input_sel, pos_input_sel};
      ticks <= 0;
    end
    else if (tad_tick && ticks < 99)
      ticks <= ticks + 1;
  end

  // outside the conversion window the bits are garbage, not the last value
  assign conv_result = (!sample_connect && ticks < 14) ? held : ~held;
endmodule

// ### tb/sadc_ctrl_tb.sv
// sadc_ctrl_tb: self-checking bench of the converter sequencer over apb
// assumes: sadc_afe_model on the analog side, reset synchronous and active low
`timescale 1ns/1ps
module sadc_ctrl_tb
  import sadc_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  hw_trigger = 3'h0;
  logic [11:0] conv_result;
  logic        sample_connect;
  logic [3:0]  pos_input_sel;
  logic        neg_input_sel;
  logic [15:0] pin_digital_mode_bits;
  logic [2:0]  reference_config;
  logic        module_on;
  logic        tad_tick;
  logic        converter_irq;
  int          mismatches = 0;
  int          checked = 0;

  always #5 clk = ~clk;

  sadc_ctrl i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_trigger(hw_trigger), .conv_result(conv_result), .sample_connect(sample_connect),
    .pos_input_sel(pos_input_sel), .neg_input_sel(neg_input_sel),
    .pin_digital_mode_bits(pin_digital_mode_bits), .reference_config(reference_config),
    .module_on(module_on), .tad_tick(tad_tick), .converter_irq(converter_irq));

  sadc_afe_model i_afe (.clk(clk), .sample_connect(sample_connect),
    .pos_input_sel(pos_input_sel), .neg_input_sel(neg_input_sel),
    .pin_digital_mode_bits(pin_digital_mode_bits), .tad_tick(tad_tick),
    .conv_result(conv_result));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // only the watchdog ends a wait for the slave
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    q = prdata;
    chk("pslverr", 32'h0, {31'h0, pslverr});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(name, exp, q);
  endtask

  task automatic wait_conn(input logic v);
    int n;
    n = 0;
    @(posedge clk);
    while (sample_connect !== v && n < 50)
    begin
      n++;
      @(posedge clk);
    end
    chk("sample_connect", {31'h0, v}, {31'h0, sample_connect});
  endtask

  // counts finished samples and converter periods since the last one
  task automatic wait_irq(output int seqs, output int ticks);
    int   n;
    logic prev;
    n = 0;
    seqs = 0;
    ticks = 0;
    prev = sample_connect;
    @(posedge clk);
    while (converter_irq !== 1'b1 && n < 4000)
    begin
      if (prev && !sample_connect)
      begin
        seqs++;
        ticks = 0;
      end
      if (!sample_connect && tad_tick)
        ticks++;
      prev = sample_connect;
      n++;
      @(posedge clk);
    end
    chk("converter_irq", 32'h1, {31'h0, converter_irq});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int a = 0; a < 7; a++)
      rd("reset value", 12'(4 * a), 32'h0);
    chk("module_on", 32'h0, {31'h0, module_on});
    wr(SADC_OFS_PIN_CFG, 32'hffffa5c3);
    @(posedge clk);
    chk("pin bits", 32'ha5c3, {16'h0, pin_digital_mode_bits});
    rd("pin cfg", SADC_OFS_PIN_CFG, 32'ha5c3);
    wr(SADC_OFS_SCAN_MASK, 32'hffff3c5a);
    rd("scan mask", SADC_OFS_SCAN_MASK, 32'h3c5a);
    wr(12'h0fc, 32'hffffffff);
    rd("unmapped", 12'h0fc, 32'h0);
    wr(SADC_OFS_PIN_CFG, 32'h0);
  endtask

  task automatic t_mux();
    for (int i = 0; i < 16; i++)
    begin
      wr(SADC_OFS_MUX_SEL, {19'h0, ~i[0], 4'(15 - i), 3'h0, i[0], 4'(i)});
      @(posedge clk);
      chk("mux a pos", 32'(i), {28'h0, pos_input_sel});
      chk("mux a neg", 32'(i[0]), {31'h0, neg_input_sel});
    end
    wr(SADC_OFS_MUX_SEL, 32'h0000ffff);
    rd("mux readback", SADC_OFS_MUX_SEL, 32'h1f1f);
    for (int c = 0; c < 8; c++)
    begin
      wr(SADC_OFS_CTRL_TWO, 32'(c) << SADC_C2_REF_LSB);
      @(posedge clk);
      chk("reference", 32'(c), {29'h0, reference_config});
    end
  endtask

  task automatic t_manual();
    int s;
    int t;
    wr(SADC_OFS_MUX_SEL, 32'h1916);
    wr(SADC_OFS_CTRL_TWO, 32'h0);
    wr(SADC_OFS_CTRL_THREE, 32'h1);
    wr(SADC_OFS_CTRL_ONE, 32'h8000);
    @(posedge clk);
    chk("module_on", 32'h1, {31'h0, module_on});
    wr(SADC_OFS_CTRL_ONE, 32'h8002);
    wait_conn(1'b1);
    wr(SADC_OFS_CTRL_ONE, 32'h8000);
    wait_irq(s, t);
    chk("sequences", 32'd1, 32'(s));
    chk("conversion periods", 32'd14, 32'(t));
    chk("no resample", 32'h0, {31'h0, sample_connect});
    rd("result", SADC_OFS_BUF_BASE, 32'h816);
    rd("done flag", SADC_OFS_CTRL_ONE, 32'h8001);
    for (int k = 1; k < 4; k++)
    begin
      wr(SADC_OFS_CTRL_ONE, 32'h0);
      wr(SADC_OFS_CTRL_ONE, 32'(k << 5) | 32'h4);
      wr(SADC_OFS_CTRL_ONE, 32'(k << 5) | 32'h8004);
      wait_conn(1'b1);
      hw_trigger <= 3'(1 << (k - 1));
      @(posedge clk);
      hw_trigger <= 3'h0;
      wait_irq(s, t);
      chk("trigger sequences", 32'd1, 32'(s));
      wait_conn(1'b1);
      wr(SADC_OFS_CTRL_ONE, 32'h0);
      rd("trigger result", SADC_OFS_BUF_BASE, 32'h816);
    end
  endtask

  task automatic t_auto();
    int s;
    int t;
    wr(SADC_OFS_MUX_SEL, 32'h1902);
    wr(SADC_OFS_CTRL_TWO, 32'h000d);
    wr(SADC_OFS_CTRL_THREE, 32'h0200);
    wr(SADC_OFS_CTRL_ONE, 32'h80e4);
    wait_irq(s, t);
    chk("sequences per irq", 32'd4, 32'(s));
    wr(SADC_OFS_CTRL_ONE, 32'h0);
    for (int i = 0; i < 4; i++)
      rd("alternating", 12'(SADC_OFS_BUF_BASE + 4 * i), i[0] ? 32'h819 : 32'h802);
    // three scan inputs but two per irq: the third is never reached
    wr(SADC_OFS_MUX_SEL, 32'h000f);
    wr(SADC_OFS_SCAN_MASK, 32'h0228);
    wr(SADC_OFS_CTRL_TWO, 32'h0404);
    wr(SADC_OFS_CTRL_ONE, 32'h80e4);
    wait_irq(s, t);
    wait_irq(s, t);
    wr(SADC_OFS_CTRL_ONE, 32'h0);
    rd("scan first", SADC_OFS_BUF_BASE, 32'h803);
    rd("scan second", 12'(SADC_OFS_BUF_BASE + 4), 32'h805);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_mux();
    t_manual();
    t_auto();
    end_of_test();
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
endmodule
